//--- rtcm_reset_tree.sv
// reset tree, reset cause latch, clock monitor and spread-spectrum sweep
// assumes fault inputs and oscillator levels are asynchronous to clk;
// standby and read strobes come from logic on clk
`default_nettype none
`include "rtcm_map.svh"

module rtcm_reset_tree #(
	parameter int SS_DEV_MIN   = -30,
	parameter int SS_DEV_MAX   = 30,
	parameter int MAIN_WIN     = 16,
	parameter int MAIN_LO      = 110,
	parameter int MAIN_HI      = 146,
	parameter int SEC_WIN      = 128,
	parameter int SEC_LO       = 14,
	parameter int SEC_HI       = 18
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rstn,
	// power-on reset sources
	input  wire logic                          digital_ground_pin_open,
	input  wire logic                          int_supply_fault,
	input  wire logic                          bandgap_fault,
	// supply rail sources
	input  wire logic                          io_supply_rails_fault,
	input  wire logic                          core_supply_rail_fault,
	input  wire logic                          mcu_supply_ov,
	input  wire logic                          mcu_supply_uv,
	input  wire logic                          boosted_supply_ok,
	// watchdog failures
	input  wire logic                          query_answer_watchdog_fail,
	input  wire logic                          pulse_period_watchdog_fail,
	// mode and software
	input  wire logic                          standby,
	input  wire logic                          ss_disable,
	input  wire logic                          supply_status_read,
	input  wire logic                          clk_status_read,
	// oscillators as sampled levels
	input  wire logic                          main_osc,
	input  wire logic                          sec_osc,
	// reset pin, open drain
	output logic                               reset_pin_o,
	output logic                               reset_pin_oe,
	// internal resets
	output logic                               por_reset,
	output logic                               watchdog_fsm_reset,
	output logic                               system_fsm_reset,
	// status
	output logic [`RTCM_CAUSE_W-1:0]           reset_cause,
	output logic                               clk_err,
	output logic                               clk_timeout_err,
	// spread-spectrum trim to the oscillator, 0.1 % units
	output logic signed [`RTCM_SS_DEV_W-1:0]   ss_trim
);
	localparam int TIMEOUT_CYC = (`RTCM_OSC_TIMEOUT_NS * `RTCM_CLK_MHZ) / 1000;
	localparam int SS_HALF_CYC = (`RTCM_CLK_MHZ * 1000) / (2 * `RTCM_SS_MOD_KHZ);

	// refused at elaboration; the 16-bit timers bound the clock rate
	if (SS_DEV_MIN < `RTCM_SS_DEV_MIN_LO
		|| SS_DEV_MIN > `RTCM_SS_DEV_MIN_HI) begin : g_bad_min
		$error("rtcm_reset_tree: sweep minimum out of range");
	end
	if (SS_DEV_MAX < `RTCM_SS_DEV_MAX_LO
		|| SS_DEV_MAX > `RTCM_SS_DEV_MAX_HI) begin : g_bad_max
		$error("rtcm_reset_tree: sweep maximum out of range");
	end
	if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65536
		|| SS_HALF_CYC < 2 || SS_HALF_CYC > 65536) begin : g_bad_rate
		$error("rtcm_reset_tree: clock rate out of range");
	end

	// deviation at a sweep position, linear from minimum to maximum
	function automatic logic signed [`RTCM_SS_DEV_W-1:0] dev_at(input logic [15:0] pos);
		int v;
		v = SS_DEV_MIN + ((SS_DEV_MAX - SS_DEV_MIN) * int'(pos)) / (SS_HALF_CYC - 1);
		return `RTCM_SS_DEV_W'(v);
	endfunction

	// ************************************
	// input synchronisers, three stages, change once two and three agree
	// ************************************
	wire [`RTCM_IN_W-1:0] raw_in;
	assign raw_in[`RTCM_IN_GND_OPEN]    = digital_ground_pin_open;
	assign raw_in[`RTCM_IN_INT_SUPPLY]  = int_supply_fault;
	assign raw_in[`RTCM_IN_BANDGAP]     = bandgap_fault;
	assign raw_in[`RTCM_IN_IO_SUPPLY]   = io_supply_rails_fault;
	assign raw_in[`RTCM_IN_CORE_SUPPLY] = core_supply_rail_fault;
	assign raw_in[`RTCM_IN_MCU_OV]      = mcu_supply_ov;
	assign raw_in[`RTCM_IN_MCU_UV]      = mcu_supply_uv;
	assign raw_in[`RTCM_IN_WD_QA]       = query_answer_watchdog_fail;
	assign raw_in[`RTCM_IN_WD_PP]       = pulse_period_watchdog_fail;
	assign raw_in[`RTCM_IN_BOOST_OK]    = boosted_supply_ok;

	logic [`RTCM_IN_W-1:0] in_s1;
	logic [`RTCM_IN_W-1:0] in_s2;
	logic [`RTCM_IN_W-1:0] in_s3;
	logic [`RTCM_IN_W-1:0] in_st;
	logic [1:0]            osc_s1;
	logic [1:0]            osc_s2;
	logic [1:0]            osc_s3;
	logic [1:0]            osc_st;
	logic [1:0]            osc_d;

	// hold until stages two and three agree; s1 feeds only s2
	wire [`RTCM_IN_W-1:0] next_in_st  = (in_s2 & in_s3) | (in_st & (in_s2 | in_s3));
	wire [1:0]            next_osc_st = (osc_s2 & osc_s3) | (osc_st & (osc_s2 | osc_s3));

	// all stages clear to 0; the tree's own registers start in reset instead
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_s1  <= '0;
			in_s2  <= '0;
			in_s3  <= '0;
			in_st  <= '0;
			osc_s1 <= 2'h0;
			osc_s2 <= 2'h0;
			osc_s3 <= 2'h0;
			osc_st <= 2'h0;
			osc_d  <= 2'h0;
		end else begin
			in_s1  <= raw_in;
			in_s2  <= in_s1;
			in_s3  <= in_s2;
			in_st  <= next_in_st;
			osc_s1 <= {sec_osc, main_osc};
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
			osc_st <= next_osc_st;
			osc_d  <= osc_st;
		end
	end

	// ************************************
	// reset hierarchy
	// ************************************
	wire por_src = in_st[`RTCM_IN_GND_OPEN] | in_st[`RTCM_IN_INT_SUPPLY]
		| in_st[`RTCM_IN_BANDGAP];
	wire rail_src = in_st[`RTCM_IN_IO_SUPPLY] | in_st[`RTCM_IN_CORE_SUPPLY];
	wire mcu_src  = in_st[`RTCM_IN_MCU_OV] | in_st[`RTCM_IN_MCU_UV];
	wire wd_src   = in_st[`RTCM_IN_WD_QA] | in_st[`RTCM_IN_WD_PP];

	// each stage reads the registered stage above, so release is ordered
	wire next_wsm = por_reset | rail_src;
	wire next_ssm = por_reset | watchdog_fsm_reset | wd_src | mcu_src;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			por_reset          <= 1'b1;
			watchdog_fsm_reset <= 1'b1;
			system_fsm_reset   <= 1'b1;
		end else begin
			por_reset          <= por_src;
			watchdog_fsm_reset <= next_wsm;
			system_fsm_reset   <= next_ssm;
		end
	end

	// ************************************
	// reset pin: drive low only, never high
	// ************************************
	wire pin_can_drive = !standby || in_st[`RTCM_IN_BOOST_OK];
	assign reset_pin_o  = 1'b0;
	assign reset_pin_oe = system_fsm_reset && pin_can_drive;

	// ************************************
	// reset cause latch, set wins over read clear
	// ************************************
	logic [`RTCM_CAUSE_W-1:0] cause_now;
	always_comb begin
		cause_now = '0;
		cause_now[`RTCM_CAUSE_POR]         = por_src;
		cause_now[`RTCM_CAUSE_IO_SUPPLY]   = in_st[`RTCM_IN_IO_SUPPLY];
		cause_now[`RTCM_CAUSE_CORE_SUPPLY] = in_st[`RTCM_IN_CORE_SUPPLY];
		cause_now[`RTCM_CAUSE_MCU_OV]      = in_st[`RTCM_IN_MCU_OV];
		cause_now[`RTCM_CAUSE_MCU_UV]      = in_st[`RTCM_IN_MCU_UV];
		cause_now[`RTCM_CAUSE_WD_QA]       = in_st[`RTCM_IN_WD_QA];
		cause_now[`RTCM_CAUSE_WD_PP]       = in_st[`RTCM_IN_WD_PP];
	end

	wire [`RTCM_CAUSE_W-1:0] next_cause =
		(supply_status_read ? '0 : reset_cause) | cause_now;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			reset_cause <= '0;
		else
			reset_cause <= next_cause;
	end

	// ************************************
	// clock monitor, both directions
	// ************************************
	wire main_edge = osc_st[0] && !osc_d[0];
	wire sec_edge  = osc_st[1] && !osc_d[1];
	wire main_done;
	wire main_bad;
	wire sec_done;
	wire sec_bad;

	// main counted over a window of secondary edges
	rtcm_freq_check #(
		.WIN_EDGES (MAIN_WIN),
		.CNT_W     (8),
		.CNT_LO    (MAIN_LO),
		.CNT_HI    (MAIN_HI)
	) u_main_chk (
		.clk          (clk),
		.rstn         (rstn),
		.win_edge     (sec_edge),
		.cnt_edge     (main_edge),
		.done         (main_done),
		.out_of_range (main_bad),
		.last_count   ()
	);

	// secondary counted over a window of main edges
	rtcm_freq_check #(
		.WIN_EDGES (SEC_WIN),
		.CNT_W     (8),
		.CNT_LO    (SEC_LO),
		.CNT_HI    (SEC_HI)
	) u_sec_chk (
		.clk          (clk),
		.rstn         (rstn),
		.win_edge     (main_edge),
		.cnt_edge     (sec_edge),
		.done         (sec_done),
		.out_of_range (sec_bad),
		.last_count   ()
	);

	// a stopped main oscillator never closes the secondary window,
	// so a separate timer on clk catches it
	logic [15:0] idle_cnt;
	wire         idle_hit  = (idle_cnt == 16'(TIMEOUT_CYC - 1));
	wire         range_err = (main_done && main_bad) || (sec_done && sec_bad);
	wire next_clk_err  = (clk_status_read ? 1'b0 : clk_err) | range_err;
	wire next_timeout  = (clk_status_read ? 1'b0 : clk_timeout_err) | idle_hit;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idle_cnt        <= 16'h0000;
			clk_err         <= 1'b0;
			clk_timeout_err <= 1'b0;
		end else begin
			if (main_edge || idle_hit)
				idle_cnt <= 16'h0000;
			else
				idle_cnt <= idle_cnt + 16'h0001;
			clk_err         <= next_clk_err;
			clk_timeout_err <= next_timeout;
		end
	end

	// ************************************
	// spread-spectrum triangular sweep
	// ************************************
	rtcm_pkg::rtcm_sweep_t sweep;
	rtcm_pkg::rtcm_sweep_t next_sweep;
	logic [15:0]           sweep_pos;
	wire                   sweep_top = (sweep_pos == 16'(SS_HALF_CYC - 1));
	wire                   sweep_bot = (sweep_pos == 16'h0000);

	always_comb begin
		next_sweep = sweep;
		unique case (sweep)
			rtcm_pkg::RTCM_SWEEP_UP: begin
				if (sweep_top)
					next_sweep = rtcm_pkg::RTCM_SWEEP_DOWN;
			end
			rtcm_pkg::RTCM_SWEEP_DOWN: begin
				if (sweep_bot)
					next_sweep = rtcm_pkg::RTCM_SWEEP_UP;
			end
		endcase
	end

	// one full up-down cycle is the modulation period
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sweep     <= rtcm_pkg::RTCM_SWEEP_UP;
			sweep_pos <= 16'h0000;
			ss_trim   <= '0;
		end else begin
			sweep <= next_sweep;
			if (sweep == rtcm_pkg::RTCM_SWEEP_UP && !sweep_top)
				sweep_pos <= sweep_pos + 16'h0001;
			else if (sweep == rtcm_pkg::RTCM_SWEEP_DOWN && !sweep_bot)
				sweep_pos <= sweep_pos - 16'h0001;
			ss_trim <= ss_disable ? '0 : dev_at(sweep_pos);
		end
	end
endmodule // rtcm_reset_tree

`default_nettype wire

//--- rtcm_map.svh
// constants of the reset tree and clock monitor: bit positions, timings
// assumes a single 250 MHz system clock; included by bare name
`ifndef RTCM_MAP_SVH
`define RTCM_MAP_SVH

// ************************************
// clock and timing
// ************************************
`define RTCM_CLK_MHZ           250
`define RTCM_OSC_TIMEOUT_NS    1000
`define RTCM_SS_MOD_KHZ        125
`define RTCM_MAIN_OSC_MHZ      16

// ************************************
// synchronised fault input positions
// ************************************
`define RTCM_IN_GND_OPEN       0
`define RTCM_IN_INT_SUPPLY     1
`define RTCM_IN_BANDGAP        2
`define RTCM_IN_IO_SUPPLY      3
`define RTCM_IN_CORE_SUPPLY    4
`define RTCM_IN_MCU_OV         5
`define RTCM_IN_MCU_UV         6
`define RTCM_IN_WD_QA          7
`define RTCM_IN_WD_PP          8
`define RTCM_IN_BOOST_OK       9
`define RTCM_IN_W              10

// ************************************
// reset cause bit positions
// ************************************
`define RTCM_CAUSE_POR         0
`define RTCM_CAUSE_IO_SUPPLY   1
`define RTCM_CAUSE_CORE_SUPPLY 2
`define RTCM_CAUSE_MCU_OV      3
`define RTCM_CAUSE_MCU_UV      4
`define RTCM_CAUSE_WD_QA       5
`define RTCM_CAUSE_WD_PP       6
`define RTCM_CAUSE_W           7

// ************************************
// spread spectrum, deviation in 0.1 % units
// ************************************
`define RTCM_SS_DEV_MIN_LO     (-50)
`define RTCM_SS_DEV_MIN_HI     (-20)
`define RTCM_SS_DEV_MAX_LO     20
`define RTCM_SS_DEV_MAX_HI     50
`define RTCM_SS_DEV_W          8

`endif

//--- rtcm_pkg.sv
// types shared by the reset tree and clock monitor
// assumes nothing of its surroundings
`default_nettype none

package rtcm_pkg;
	// direction of the triangular spread-spectrum sweep
	typedef enum logic [0:0] {
		RTCM_SWEEP_UP   = 1'b0,
		RTCM_SWEEP_DOWN = 1'b1
	} rtcm_sweep_t;
endpackage

`default_nettype wire

//--- rtcm_freq_check.sv
// windowed frequency comparison of one oscillator against another
// assumes both edge inputs are one-cycle pulses on clk
`default_nettype none
`include "rtcm_map.svh"

module rtcm_freq_check #(
	parameter int WIN_EDGES = 16,
	parameter int CNT_W     = 8,
	parameter int CNT_LO    = 110,
	parameter int CNT_HI    = 146
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// oscillator edges
	input  wire logic             win_edge,
	input  wire logic             cnt_edge,
	// result
	output logic                  done,
	output logic                  out_of_range,
	output logic [CNT_W-1:0]      last_count
);
	// refused at elaboration: the window counter is 16 bits wide
	if (WIN_EDGES < 2 || WIN_EDGES > 65536
		|| CNT_LO > CNT_HI || CNT_HI >= (1 << CNT_W)) begin : g_bad_cfg
		$error("rtcm_freq_check: bad window or limits");
	end

	logic [15:0]      win_cnt;
	logic [CNT_W-1:0] cnt;
	wire              win_end = win_edge && (win_cnt == 16'(WIN_EDGES - 1));
	wire              cnt_sat = (cnt == {CNT_W{1'b1}});
	wire [CNT_W-1:0]  cnt_fin = (cnt_edge && !cnt_sat) ? cnt + 1'b1 : cnt;
	wire              bad     = (cnt_fin < CNT_W'(CNT_LO)) || (cnt_fin > CNT_W'(CNT_HI));

	// ************************************
	// window timed by one clock, counting the other
	// ************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			win_cnt      <= 16'h0000;
			cnt          <= '0;
			done         <= 1'b0;
			out_of_range <= 1'b0;
			last_count   <= '0;
		end else begin
			done <= win_end;
			if (win_end) begin
				win_cnt      <= 16'h0000;
				cnt          <= '0;
				last_count   <= cnt_fin;
				out_of_range <= bad;
			end else begin
				if (win_edge)
					win_cnt <= win_cnt + 16'h0001;
				cnt <= cnt_fin;
			end
		end
	end
endmodule // rtcm_freq_check

`default_nettype wire

//--- rtcm_reset_tree_assertions.sv
// checker: port relations of rtcm_reset_tree
// assumes a bind onto the design, one clock domain
`default_nettype none
module rtcm_reset_tree_assertions #(
	parameter int SS_DEV_MIN = -30,
	parameter int SS_DEV_MAX = 30
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// sources and modes
	input wire logic        digital_ground_pin_open,
	input wire logic        io_supply_rails_fault,
	input wire logic        mcu_supply_ov,
	input wire logic        standby,
	input wire logic        ss_disable,
	input wire logic        clk_status_read,
	input wire logic        main_osc,
	// design outputs
	input wire logic        reset_pin_o,
	input wire logic        reset_pin_oe,
	input wire logic        por_reset,
	input wire logic        watchdog_fsm_reset,
	input wire logic        system_fsm_reset,
	input wire logic        clk_timeout_err,
	input wire logic signed [7:0] ss_trim
);
	logic [8:0]      idle_cnt;
	logic            main_q;
	wire logic [8:0] next_idle_cnt;
	// still cycles of main; a read restarts it, as it may clear the flag
	assign next_idle_cnt = (main_osc != main_q || clk_status_read) ? 9'h000 :
		idle_cnt + {8'h00, idle_cnt != 9'h1FF};
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idle_cnt <= 9'h000;
			main_q   <= 1'b0;
		end else begin
			idle_cnt <= next_idle_cnt;
			main_q   <= main_osc;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// reset tree and pin
	chk_pin_data_low:
	assert property (!reset_pin_o) else $error("pin data high");
	chk_por_forces:
	assert property (por_reset |=> watchdog_fsm_reset ##1 system_fsm_reset) else $error("por alone");
	chk_release_order:
	assert property ($fell(system_fsm_reset) |-> !(por_reset || watchdog_fsm_reset))
		else $error("early release");
	chk_pin_idle:
	assert property (!system_fsm_reset |-> !reset_pin_oe) else $error("pin low idle");
	chk_pin_active:
	assert property (system_fsm_reset && !standby |-> reset_pin_oe) else $error("pin not low");
	chk_por_source:
	assert property (digital_ground_pin_open [*7] |=> por_reset) else $error("no por");
	chk_wsm_source:
	assert property (io_supply_rails_fault [*7] |=> watchdog_fsm_reset) else $error("no wsm");
	chk_mcu_pin:
	assert property ((mcu_supply_ov && !standby) [*8] |=> reset_pin_oe) else $error("no pin");
	// sweep and clock
	chk_trim_bounds:
	assert property (ss_trim >= SS_DEV_MIN && ss_trim <= SS_DEV_MAX) else $error("trim out");
	chk_trim_off:
	assert property (ss_disable [*2] |-> ss_trim == 8'h00) else $error("trim on");
	chk_stuck_main:
	assert property (idle_cnt == 9'h118 |-> clk_timeout_err) else $error("no timeout");
	cover property ($rose(por_reset));
	cover property (standby && system_fsm_reset && !reset_pin_oe);
	cover property ($rose(clk_timeout_err));
endmodule // rtcm_reset_tree_assertions
`default_nettype wire

//--- rtcm_host_model.sv
// far side: host reset line with pull-up, both oscillators
// assumes half periods in ps are set at time zero
`default_nettype none
module rtcm_host_model (
	// oscillator settings
	input wire logic [17:0] main_half_ps,
	input wire logic [17:0] sec_half_ps,
	input wire logic        main_run,
	// device pin enable
	input wire logic        reset_pin_oe,
	// oscillators and line
	output logic            main_osc,
	output logic            sec_osc,
	output logic            reset_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// main oscillator; when stopped it holds its level
	initial begin
		main_osc = 1'b0;
		forever begin
			#((main_half_ps + 18'h00001) * 1ps);
			main_osc = main_run ? !main_osc : main_osc;
		end
	end
	// secondary oscillator, free running
	initial begin
		sec_osc = 1'b0;
		forever begin
			#((sec_half_ps + 18'h00001) * 1ps);
			sec_osc = !sec_osc;
		end
	end
	// pull-up wins only while nobody pulls low
	assign reset_line = reset_pin_oe ? 1'b0 : 1'b1;
endmodule // rtcm_host_model
`default_nettype wire

//--- rtcm_reset_tree_tb.sv
// bench: reset, then fault rows, standby, clock monitor, sweep
// assumes host model and checker compiled first
`default_nettype none
`include "rtcm_map.svh"
module rtcm_reset_tree_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SS_DEV_MIN = -30;
	localparam int SS_DEV_MAX = 30;
	logic clk, rstn, boosted_supply_ok, standby, ss_disable, main_run;
	logic supply_status_read, clk_status_read;
	logic [8:0] flt;
	logic [17:0] main_half_ps, sec_half_ps;
	wire logic digital_ground_pin_open, int_supply_fault, bandgap_fault, io_supply_rails_fault;
	wire logic core_supply_rail_fault, mcu_supply_ov, mcu_supply_uv;
	wire logic query_answer_watchdog_fail, pulse_period_watchdog_fail;
	wire logic main_osc, sec_osc, reset_line, reset_pin_o, reset_pin_oe, clk_err;
	wire logic por_reset, watchdog_fsm_reset, system_fsm_reset, clk_timeout_err;
	wire logic [`RTCM_CAUSE_W-1:0] reset_cause;
	wire logic signed [`RTCM_SS_DEV_W-1:0] ss_trim;
	logic signed [7:0] mx, mn, prv;
	int fail_count, checks, t, ent, per;
	// row: faults, expected por/wsm/ssm, expected cause
	logic [18:0] rows [9] = '{
		{9'h001, 3'h7, 7'h01}, {9'h002, 3'h7, 7'h01}, {9'h004, 3'h7, 7'h01},
		{9'h008, 3'h3, 7'h02}, {9'h010, 3'h3, 7'h04}, {9'h020, 3'h1, 7'h08},
		{9'h040, 3'h1, 7'h10}, {9'h080, 3'h1, 7'h20}, {9'h100, 3'h1, 7'h40}};
	assign {pulse_period_watchdog_fail, query_answer_watchdog_fail, mcu_supply_uv,
		mcu_supply_ov, core_supply_rail_fault, io_supply_rails_fault, bandgap_fault,
		int_supply_fault, digital_ground_pin_open} = flt;
	rtcm_reset_tree #(.SS_DEV_MIN(SS_DEV_MIN), .SS_DEV_MAX(SS_DEV_MAX)) dut_u (
		.clk(clk), .rstn(rstn), .digital_ground_pin_open(digital_ground_pin_open),
		.int_supply_fault(int_supply_fault), .bandgap_fault(bandgap_fault),
		.io_supply_rails_fault(io_supply_rails_fault),
		.core_supply_rail_fault(core_supply_rail_fault), .mcu_supply_ov(mcu_supply_ov),
		.mcu_supply_uv(mcu_supply_uv), .boosted_supply_ok(boosted_supply_ok),
		.query_answer_watchdog_fail(query_answer_watchdog_fail),
		.pulse_period_watchdog_fail(pulse_period_watchdog_fail),
		.standby(standby), .ss_disable(ss_disable), .supply_status_read(supply_status_read),
		.clk_status_read(clk_status_read), .main_osc(main_osc), .sec_osc(sec_osc),
		.reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe), .por_reset(por_reset),
		.watchdog_fsm_reset(watchdog_fsm_reset), .system_fsm_reset(system_fsm_reset),
		.reset_cause(reset_cause), .clk_err(clk_err), .clk_timeout_err(clk_timeout_err),
		.ss_trim(ss_trim));
	rtcm_host_model host_u (
		.main_half_ps(main_half_ps), .sec_half_ps(sec_half_ps), .main_run(main_run),
		.reset_pin_oe(reset_pin_oe), .main_osc(main_osc), .sec_osc(sec_osc),
		.reset_line(reset_line));
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask
	task automatic compare(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// hang guard, well past the longest run
	initial begin
		#200us;
		fail_count++;
		complete_run;
	end
	// main sequence
	initial begin
		rstn = 1'b0;
		flt = 9'h000;
		{boosted_supply_ok, standby, ss_disable, supply_status_read, clk_status_read} = 5'h10;
		main_run = 1'b1;
		main_half_ps = 18'h07A12;
		sec_half_ps = 18'h3D090;
		cyc(2);
		compare("in reset", {por_reset, watchdog_fsm_reset, system_fsm_reset, reset_line}, 4'hE);
		compare("reset status", {clk_err, clk_timeout_err, reset_cause}, 9'h000);
		compare("pin data", reset_pin_o, 1'b0);
		rstn = 1'b1;
		cyc(12);
		pulse(supply_status_read);
		// one source per row: assert, latch, release, clear
		foreach (rows[i]) begin
			flt = rows[i][18:10];
			cyc(10);
			compare("tree", {por_reset, watchdog_fsm_reset, system_fsm_reset, reset_line},
				{rows[i][9:7], 1'b0});
			pulse(supply_status_read);
			compare("held cause", reset_cause, rows[i][6:0]);
			flt = 9'h000;
			cyc(10);
			compare("released", {por_reset, watchdog_fsm_reset, system_fsm_reset, reset_line}, 4'h1);
			compare("latched", reset_cause, rows[i][6:0]);
			pulse(supply_status_read);
			compare("cleared", reset_cause, 7'h00);
		end
		// standby pulls low only with the boost supply up
		standby = 1'b1;
		flt = 9'h020;
		cyc(10);
		compare("standby boost", reset_line, 1'b0);
		boosted_supply_ok = 1'b0;
		cyc(6);
		compare("standby no boost", {system_fsm_reset, reset_line}, 2'h3);
		{standby, boosted_supply_ok, flt} = {2'h1, 9'h000};
		cyc(4500);
		pulse(clk_status_read);
		cyc(4500);
		compare("clk nominal", {clk_err, clk_timeout_err}, 2'h0);
		main_half_ps = 18'h061A8;
		cyc(4500);
		compare("main fast", clk_err, 1'b1);
		main_half_ps = 18'h07A12;
		cyc(4500);
		pulse(clk_status_read);
		sec_half_ps = 18'h30D40;
		cyc(4500);
		compare("sec fast", clk_err, 1'b1);
		sec_half_ps = 18'h3D090;
		main_run = 1'b0;
		cyc(300);
		compare("main stuck", clk_timeout_err, 1'b1);
		main_run = 1'b1;
		cyc(4500);
		pulse(clk_status_read);
		compare("clk cleared", {clk_err, clk_timeout_err}, 2'h0);
		// sweep extremes and period between peak entries
		mx = 8'sh00;
		mn = 8'sh00;
		prv = ss_trim;
		for (t = 1; t <= 4200; t++) begin
			cyc(1);
			mx = (ss_trim > mx) ? ss_trim : mx;
			mn = (ss_trim < mn) ? ss_trim : mn;
			if (ss_trim == 8'(SS_DEV_MAX) && prv != 8'(SS_DEV_MAX)) begin
				per = t - ent;
				ent = t;
			end
			prv = ss_trim;
		end
		compare("sweep max", mx, 8'(SS_DEV_MAX));
		compare("sweep min", mn, 8'(SS_DEV_MIN));
		compare("sweep period", 16'(per), 16'h07D0);
		ss_disable = 1'b1;
		cyc(3);
		compare("sweep off", ss_trim, 8'h00);
		// reset again mid-run with a core fault latched
		flt = 9'h010;
		cyc(10);
		rstn = 1'b0;
		cyc(2);
		compare("mid reset", {por_reset, watchdog_fsm_reset, system_fsm_reset, reset_line}, 4'hE);
		compare("mid reset status", {clk_err, reset_cause, ss_trim}, 16'h0000);
		flt = 9'h000;
		rstn = 1'b1;
		cyc(12);
		compare("mid released", {por_reset, watchdog_fsm_reset, system_fsm_reset, reset_line}, 4'h1);
		compare("mid cause", reset_cause, 7'h00);
		compare("mid pin data", reset_pin_o, 1'b0);
		complete_run;
	end
endmodule // rtcm_reset_tree_tb
bind rtcm_reset_tree rtcm_reset_tree_assertions #(
	.SS_DEV_MIN(SS_DEV_MIN),
	.SS_DEV_MAX(SS_DEV_MAX)
) chk_u (
	.clk(clk), .rstn(rstn), .digital_ground_pin_open(digital_ground_pin_open),
	.io_supply_rails_fault(io_supply_rails_fault), .mcu_supply_ov(mcu_supply_ov),
	.standby(standby), .ss_disable(ss_disable), .clk_status_read(clk_status_read),
	.main_osc(main_osc), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
	.por_reset(por_reset), .watchdog_fsm_reset(watchdog_fsm_reset),
	.system_fsm_reset(system_fsm_reset), .clk_timeout_err(clk_timeout_err),
	.ss_trim(ss_trim));
`default_nettype wire
